// [pbl_cfg.svh]
`ifndef PBL_CFG_SVH
`define PBL_CFG_SVH

// register offsets on the plain register port
`define PBL_ADDR_W 8
`define PBL_OFF_CTRL 8'h16
`define PBL_OFF_ERRCNT 8'h20
`define PBL_OFF_IRQ_STAT 8'h21
`define PBL_OFF_IRQ_MASK 8'h22

// self_test_control field positions
`define PBL_B_CNT_MODE 14
`define PBL_B_PKT_TYPE 13
`define PBL_B_GEN_EN 12
`define PBL_B_LOCK 11
`define PBL_B_SYNC_LOSS 10
`define PBL_B_GEN_STAT 9
`define PBL_B_LINE_FWD 6
`define PBL_F_LB_HI 5
`define PBL_F_LB_LO 2
`define PBL_F_RSV_HI 1

// fixed value of the read-only reserved pair at bits 8:7
`define PBL_RSV87_VAL 2'h2
`define PBL_CTRL_RST 16'h0000

// interrupt status bit positions
`define PBL_IRQ_LOSS 0
`define PBL_IRQ_LOCK 1
`define PBL_IRQ_CNT 2
`define PBL_IRQ_DONE 3
`define PBL_IRQ_N 4

// timing counts in bit times (one bit per enabled cycle)
`define PBL_PKT_BITS 12000
`define PBL_GAP_BITS 96
`define PBL_LOCK_MATCHES 32
`define PBL_LOSS_MISSES 4

`endif

// [pbl_pkg.sv]
package pbl_pkg;

  typedef enum logic [3:0] {
    PBL_LB_NORMAL = 4'h0,
    PBL_LB_PCS = 4'h1,
    PBL_LB_ANALOG = 4'h2,
    PBL_LB_REVERSE = 4'h4,
    PBL_LB_RSVD = 4'h8
  } pbl_lb_t;

  typedef enum logic [1:0] {
    PBL_GEN_IDLE = 2'h0,
    PBL_GEN_RUN = 2'h1,
    PBL_GEN_GAP = 2'h2,
    PBL_GEN_DONE = 2'h3
  } pbl_gen_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pbl_bus_t;

  typedef struct packed {
    logic bit_v;
    logic valid;
    logic sop;
  } pbl_tx_t;

endpackage : pbl_pkg

// [pbl_prbs_gen.sv]
`timescale 1ns/1ps
// fibonacci lfsr, advances one bit per i_step
module pbl_prbs_gen #(
  parameter int W = 15,
  parameter int TAP = 14
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic i_step,
  output logic o_bit
);

  initial begin
    if (W < 3 || TAP >= W || TAP < 1) $error("pbl_prbs_gen: bad taps");
  end

  typedef struct packed {
    logic [W-1:0] sh;
  } pbl_gen_st_t;

  pbl_gen_st_t st_q;
  pbl_gen_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (i_load) begin
      st_d.sh = {W{1'b1}};
    end else if (i_step) begin
      st_d.sh = {st_q.sh[W-2:0], st_q.sh[W-1] ^ st_q.sh[TAP-1]};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= '{sh: {W{1'b1}}};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_bit = st_q.sh[W-1] ^ st_q.sh[TAP-1];

endmodule : pbl_prbs_gen

// [pbl_err_cnt.sv]
`timescale 1ns/1ps
module pbl_err_cnt #(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_inc,
  input wire logic i_continuous,
  input wire logic i_clr,
  output logic [W-1:0] o_count,
  output logic o_wrap
);

  initial begin
    if (W < 2 || W > 16) $error("pbl_err_cnt: width must be 2..16");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic wrap;
  } pbl_cnt_st_t;

  pbl_cnt_st_t st_q;
  pbl_cnt_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.wrap = 1'b0;
    if (i_inc && (st_q.cnt == {W{1'b1}}) && i_continuous) begin
      // a clear in the same cycle does not swallow the wrap
      st_d.cnt = '0;
      st_d.wrap = 1'b1;
    end else if (i_clr) begin
      // the read has already returned the old count, so an increment now is dropped
      st_d.cnt = '0;
    end else if (i_inc && (st_q.cnt != {W{1'b1}})) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
    // single mode: at maximum the increment is dropped
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_count = st_q.cnt;
  assign o_wrap = st_q.wrap;

endmodule : pbl_err_cnt

// [pbl_top.sv]
// Operation
// - continuous counter mode: pulse at maximum error count, then restart from zero
// - single counter mode: checker stops counting errors at maximum value
// - prbs type with generator on: continuous prbs-filled packets
// - prbs type with generator off: checker still active on received data
// - constant type with generator on: one constant packet, no prbs gen or check
// - generation enable starts the generator, clearing it stops it
// - read-only lock bit is one while checker is locked to received stream
// - sync-loss flag latches high on loss of sync until register is read
// - read-only generator status is one while generator is producing packets
// - loopback select: 0000 normal, 0001 pcs, 0010 analog
// - loopback select 0100 is reverse; 1000 is reserved, not used
// - in xmii loopback, forward bit passes tx data to line or suppresses it
`include "pbl_cfg.svh"
`timescale 1ns/1ps
module pbl_top #(
  parameter int CNT_W = 16,
  parameter int PKT_BITS = `PBL_PKT_BITS,
  parameter int GAP_BITS = `PBL_GAP_BITS,
  parameter int LOCK_MATCHES = `PBL_LOCK_MATCHES,
  parameter int LOSS_MISSES = `PBL_LOSS_MISSES,
  parameter logic CONST_BIT = 1'b1
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [15:0] O_RDATA,
  input wire logic I_TX_READY,
  output logic O_TX_BIT,
  output logic O_TX_VALID,
  output logic O_TX_SOP,
  input wire logic I_RX_BIT,
  input wire logic I_RX_VALID,
  output logic [3:0] O_LOOPBACK,
  output logic O_LINE_TX_EN,
  output logic O_ERR_WRAP,
  output logic O_IRQ
);

  initial begin
    if (PKT_BITS < 2 || PKT_BITS > 65535) $error("pbl_top: PKT_BITS out of range");
    if (GAP_BITS < 1 || GAP_BITS > 65535) $error("pbl_top: GAP_BITS out of range");
    if (LOCK_MATCHES < 1 || LOCK_MATCHES > 255) $error("pbl_top: LOCK_MATCHES out of range");
    if (LOSS_MISSES < 1 || LOSS_MISSES > 15) $error("pbl_top: LOSS_MISSES out of range");
  end

  // end points of the 16-bit bit and gap counters, limits of the 8-bit match and 4-bit miss counters; the range checks above keep them representable
  localparam logic [15:0] PKT_LAST = 16'(PKT_BITS - 1);
  localparam logic [15:0] GAP_LAST = 16'(GAP_BITS - 1);
  localparam logic [7:0] LOCK_N = 8'(LOCK_MATCHES);
  localparam logic [3:0] LOSS_N = 4'(LOSS_MISSES);

  // only listed codes are accepted; anything else, reserved 1000 included, is refused
  function automatic logic lb_legal(input logic [3:0] v);
    case (v)
      pbl_pkg::PBL_LB_NORMAL,
      pbl_pkg::PBL_LB_PCS,
      pbl_pkg::PBL_LB_ANALOG,
      pbl_pkg::PBL_LB_REVERSE: lb_legal = 1'b1;
      default: lb_legal = 1'b0;
    endcase
  endfunction : lb_legal

  // pcs and analog loop the xmii transmit data back inside the device
  function automatic logic lb_xmii(input logic [3:0] v);
    lb_xmii = (v == pbl_pkg::PBL_LB_PCS) || (v == pbl_pkg::PBL_LB_ANALOG);
  endfunction : lb_xmii

  typedef struct packed {
    logic cnt_mode;
    logic pkt_type;
    logic gen_en;
    logic [3:0] lb;
    logic line_fwd;
    logic [1:0] rsv;
    logic sync_loss;
    logic locked;
    pbl_pkg::pbl_gen_t gen;
    logic [15:0] bit_cnt;
    logic [14:0] chk_sh;
    logic [7:0] match_cnt;
    logic [3:0] miss_cnt;
    logic [`PBL_IRQ_N-1:0] irq_stat;
    logic [`PBL_IRQ_N-1:0] irq_mask;
    logic [15:0] rdata;
    pbl_pkg::pbl_tx_t tx;
  } pbl_top_st_t;

  pbl_top_st_t st_q;
  pbl_top_st_t st_d;
  pbl_pkg::pbl_bus_t bus;
  logic prbs_bit;
  logic prbs_load;
  logic prbs_step;

  logic chk_en;
  logic err_inc;
  logic err_clr;
  logic err_wrap;
  logic [CNT_W-1:0] err_count;

  logic tx_slot;
  logic [`PBL_IRQ_N-1:0] irq_ev;
  logic [15:0] ctrl_view;

  assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

  // checker runs only for prbs packet type, whatever the generator does
  assign chk_en = st_q.pkt_type;
  // datapath ready gates every bit and every gap cycle
  assign tx_slot = I_TX_READY;
  // reseeding in idle makes every run start from the same sequence
  assign prbs_load = (st_q.gen == pbl_pkg::PBL_GEN_IDLE);
  assign prbs_step = (st_q.gen == pbl_pkg::PBL_GEN_RUN) && st_q.pkt_type && tx_slot;
  // reading the count clears it; an increment landing on that read is lost, except one that wraps a full count in continuous mode
  assign err_clr = bus.rd && (bus.addr == `PBL_OFF_ERRCNT);

  pbl_prbs_gen #(
    .W(15),
    .TAP(14)
  ) u_gen (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_load(prbs_load),
    .i_step(prbs_step),
    .o_bit(prbs_bit)
  );

  pbl_err_cnt #(
    .W(CNT_W)
  ) u_cnt (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_inc(err_inc),
    .i_continuous(st_q.cnt_mode),
    .i_clr(err_clr),
    .o_count(err_count),
    .o_wrap(err_wrap)
  );

  always_comb begin
    // status fields come from live state, not from stored write data
    ctrl_view = 16'h0000;
    ctrl_view[`PBL_B_CNT_MODE] = st_q.cnt_mode;
    ctrl_view[`PBL_B_PKT_TYPE] = st_q.pkt_type;
    ctrl_view[`PBL_B_GEN_EN] = st_q.gen_en;
    ctrl_view[`PBL_B_LOCK] = st_q.locked;
    ctrl_view[`PBL_B_SYNC_LOSS] = st_q.sync_loss;
    // done after a single constant packet reads as off
    ctrl_view[`PBL_B_GEN_STAT] = (st_q.gen == pbl_pkg::PBL_GEN_RUN) ||
                                 (st_q.gen == pbl_pkg::PBL_GEN_GAP);
    ctrl_view[8:7] = `PBL_RSV87_VAL;
    ctrl_view[`PBL_B_LINE_FWD] = st_q.line_fwd;
    ctrl_view[`PBL_F_LB_HI:`PBL_F_LB_LO] = st_q.lb;
    ctrl_view[`PBL_F_RSV_HI:0] = st_q.rsv;
  end

  always_comb begin
    logic mism;
    logic loss_ev;
    logic lock_ev;
    logic done_ev;
    logic [3:0] new_lb;
    mism = 1'b0;
    loss_ev = 1'b0;
    lock_ev = 1'b0;
    done_ev = 1'b0;
    new_lb = bus.wdata[`PBL_F_LB_HI:`PBL_F_LB_LO];
    err_inc = 1'b0;
    st_d = st_q;
    st_d.tx.valid = 1'b0;
    st_d.tx.sop = 1'b0;

    // generator sequencing; one bit leaves per cycle the datapath is ready
    case (st_q.gen)
      pbl_pkg::PBL_GEN_IDLE: begin
        st_d.bit_cnt = 16'h0000;
        if (st_q.gen_en) begin
          st_d.gen = pbl_pkg::PBL_GEN_RUN;
        end
      end
      pbl_pkg::PBL_GEN_RUN: begin
        // ready low stalls the packet; bit counter and lfsr hold together
        if (tx_slot) begin
          st_d.tx.valid = 1'b1;
          st_d.tx.sop = (st_q.bit_cnt == 16'h0000);
          st_d.tx.bit_v = st_q.pkt_type ? prbs_bit : CONST_BIT;
          // last bit: prbs type rests for the gap, constant type stops for good
          if (st_q.bit_cnt == PKT_LAST) begin
            st_d.bit_cnt = 16'h0000;
            if (st_q.pkt_type) begin
              st_d.gen = pbl_pkg::PBL_GEN_GAP;
            end else begin
              st_d.gen = pbl_pkg::PBL_GEN_DONE;
              done_ev = 1'b1;
            end
          end else begin
            st_d.bit_cnt = st_q.bit_cnt + 16'h0001;
          end
        end
      end
      pbl_pkg::PBL_GEN_GAP: begin
        // the gap counts ready cycles, so a stalled datapath stretches it
        if (tx_slot) begin
          if (st_q.bit_cnt == GAP_LAST) begin
            st_d.bit_cnt = 16'h0000;
            st_d.gen = st_q.pkt_type ? pbl_pkg::PBL_GEN_RUN : pbl_pkg::PBL_GEN_DONE;
          end else begin
            st_d.bit_cnt = st_q.bit_cnt + 16'h0001;
          end
        end
      end
      pbl_pkg::PBL_GEN_DONE: begin
        // single packet sent; a new one needs enable cleared and set again
        st_d.bit_cnt = 16'h0000;
      end
      default: begin
        st_d.gen = pbl_pkg::PBL_GEN_IDLE;
      end
    endcase
    if (!st_q.gen_en) begin
      st_d.gen = pbl_pkg::PBL_GEN_IDLE;
      st_d.tx.valid = 1'b0;
      st_d.tx.sop = 1'b0;
    end

    // self-synchronising checker: prediction from the last received bits
    if (!chk_en) begin
      st_d.locked = 1'b0;
      st_d.match_cnt = 8'h00;
      st_d.miss_cnt = 4'h0;
    end else if (I_RX_VALID) begin
      mism = (st_q.chk_sh[14] ^ st_q.chk_sh[13]) != I_RX_BIT;
      st_d.chk_sh = {st_q.chk_sh[13:0], I_RX_BIT};
      // chance matches before the history fills can lock early; the first
      // wrong prediction after that is then counted as an error
      if (!st_q.locked) begin
        st_d.match_cnt = mism ? 8'h00 : st_q.match_cnt + 8'h01;
        if (!mism && (st_q.match_cnt + 8'h01 == LOCK_N)) begin
          st_d.locked = 1'b1;
          st_d.match_cnt = 8'h00;
          st_d.miss_cnt = 4'h0;
          lock_ev = 1'b1;
        end
      end else begin
        // a lone bit error is counted; only a run of misses breaks lock
        err_inc = mism;
        st_d.miss_cnt = mism ? st_q.miss_cnt + 4'h1 : 4'h0;
        // the miss that breaks lock is still counted above
        if (mism && (st_q.miss_cnt + 4'h1 == LOSS_N)) begin
          st_d.locked = 1'b0;
          st_d.miss_cnt = 4'h0;
          loss_ev = 1'b1;
        end
      end
    end

    // events of this cycle; the counter wrap arrives one cycle after its error
    irq_ev = '0;
    irq_ev[`PBL_IRQ_LOSS] = loss_ev;
    irq_ev[`PBL_IRQ_LOCK] = lock_ev;
    irq_ev[`PBL_IRQ_CNT] = err_wrap;
    irq_ev[`PBL_IRQ_DONE] = done_ev;

    // register writes
    st_d.rdata = 16'h0000;
    if (bus.wr) begin
      case (bus.addr)
        `PBL_OFF_CTRL: begin
          st_d.cnt_mode = bus.wdata[`PBL_B_CNT_MODE];
          st_d.pkt_type = bus.wdata[`PBL_B_PKT_TYPE];
          st_d.gen_en = bus.wdata[`PBL_B_GEN_EN];
          // reserved pair 1:0 is plain storage and reads back as written
          st_d.rsv = bus.wdata[`PBL_F_RSV_HI:0];
          if (lb_legal(new_lb)) begin
            st_d.lb = new_lb;
          end
          // forward bit only takes when the resulting mode is an xmii loopback
          st_d.line_fwd = bus.wdata[`PBL_B_LINE_FWD] && lb_xmii(st_d.lb);
        end
        `PBL_OFF_IRQ_STAT: begin
          st_d.irq_stat = st_q.irq_stat & ~bus.wdata[`PBL_IRQ_N-1:0];
        end
        `PBL_OFF_IRQ_MASK: begin
          st_d.irq_mask = bus.wdata[`PBL_IRQ_N-1:0];
        end
        default: begin
        end
      endcase
    end

    // register reads, answered in the next cycle
    if (bus.rd) begin
      case (bus.addr)
        `PBL_OFF_CTRL: begin
          st_d.rdata = ctrl_view;
          st_d.sync_loss = 1'b0;
        end
        `PBL_OFF_ERRCNT: st_d.rdata = 16'(err_count);
        `PBL_OFF_IRQ_STAT: st_d.rdata = {{(16 - `PBL_IRQ_N){1'b0}}, st_q.irq_stat};
        `PBL_OFF_IRQ_MASK: st_d.rdata = {{(16 - `PBL_IRQ_N){1'b0}}, st_q.irq_mask};
        default: st_d.rdata = 16'h0000;
      endcase
    end

    // events set after the clears so a same-cycle loss or event is kept
    if (loss_ev) begin
      st_d.sync_loss = 1'b1;
    end
    st_d.irq_stat = st_d.irq_stat | irq_ev;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st_q <= '0;
      st_q.gen <= pbl_pkg::PBL_GEN_IDLE;
      st_q.lb <= pbl_pkg::PBL_LB_NORMAL;
      // history starts at all ones, the same as the generator seed
      st_q.chk_sh <= 15'h7FFF;
    end else begin
      st_q <= st_d;
    end
  end

  assign O_RDATA = st_q.rdata;
  assign O_TX_BIT = st_q.tx.bit_v;
  assign O_TX_VALID = st_q.tx.valid;
  assign O_TX_SOP = st_q.tx.sop;
  assign O_LOOPBACK = st_q.lb;
  // outside xmii loopback the line always gets transmit data
  assign O_LINE_TX_EN = !lb_xmii(st_q.lb) || st_q.line_fwd;
  assign O_ERR_WRAP = err_wrap;
  // level output: drops as soon as the status bit is cleared or masked
  assign O_IRQ = |(st_q.irq_stat & st_q.irq_mask);

endmodule : pbl_top

// [pbl_top_chk.sv]
`timescale 1ns/1ps
module pbl_top_chk (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [15:0] O_RDATA,
  input wire logic I_TX_READY,
  input wire logic O_TX_VALID,
  input wire logic O_TX_SOP,
  input wire logic I_RX_VALID,
  input wire logic [3:0] O_LOOPBACK,
  input wire logic O_LINE_TX_EN,
  input wire logic O_ERR_WRAP,
  input wire logic O_IRQ
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // written code kept one cycle so the update can be judged after the edge
  logic [3:0] lb_q;
  wire ctl_wr = I_WR && I_ADDR == 8'h16;
  always_ff @(posedge I_CLK) begin
    lb_q <= I_WDATA[5:2];
  end
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 16'h0000)
    else $error("read data outside read cycle");
  a_lb_legal: assert property (O_LOOPBACK inside {4'h0, 4'h1, 4'h2, 4'h4})
    else $error("loopback code illegal");
  // a refused code must leave the previous selection in place
  a_lb_write: assert property (ctl_wr |=> O_LOOPBACK ==
    ((lb_q inside {4'h0, 4'h1, 4'h2, 4'h4}) ? lb_q : $past(O_LOOPBACK)))
    else $error("loopback write wrong");
  a_line_en: assert property (!(O_LOOPBACK inside {4'h1, 4'h2}) |-> O_LINE_TX_EN)
    else $error("line suppressed outside loopback");
  a_sop_valid: assert property (O_TX_SOP |-> O_TX_VALID)
    else $error("start without bit");
  a_tx_ready: assert property (O_TX_VALID |-> $past(I_TX_READY))
    else $error("bit without ready");
  a_gen_stop: assert property (ctl_wr && !I_WDATA[12] |-> ##3 !O_TX_VALID)
    else $error("generator still sending");
  a_irq_mask: assert property (I_WR && I_ADDR == 8'h22 && I_WDATA[3:0] == 4'h0 |=> !O_IRQ)
    else $error("irq with all masked");
  a_wrap_pulse: assert property (O_ERR_WRAP |=> !O_ERR_WRAP)
    else $error("wrap longer than a pulse");
  a_wrap_cause: assert property (O_ERR_WRAP |-> $past(I_RX_VALID) || $past(I_RX_VALID, 2))
    else $error("wrap without received bit");
  c_sop: cover property (O_TX_SOP);
  c_wrap: cover property (O_ERR_WRAP);
  c_irq: cover property (O_IRQ);
  c_fwd_off: cover property (!O_LINE_TX_EN);
endmodule : pbl_top_chk
bind pbl_top pbl_top_chk u_chk (.I_CLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
  .I_TX_READY, .O_TX_VALID, .O_TX_SOP, .I_RX_VALID, .O_LOOPBACK, .O_LINE_TX_EN, .O_ERR_WRAP,
  .O_IRQ);

// [pbl_top_tb.sv]
`timescale 1ns/1ps
module pbl_top_tb;
  localparam logic [7:0] CT = 8'h16;
  logic I_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic [7:0] I_ADDR = 8'h00;
  logic [15:0] I_WDATA = 16'h0000;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic I_TX_READY = 1'b1;
  logic I_RX_BIT = 1'b0;
  logic I_RX_VALID = 1'b0;
  logic [15:0] O_RDATA;
  logic [3:0] O_LOOPBACK;
  logic O_TX_BIT, O_TX_VALID, O_TX_SOP, O_LINE_TX_EN, O_ERR_WRAP, O_IRQ;
  int errors = 0;
  int checked = 0;
  int wraps = 0;
  int cyc = 0;
  int nv, ns, n1;
  logic [14:0] h = 15'h7FFF;
  logic [15:0] v;
  logic [3:0] el;
  logic [3:0] cd [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
  logic b [20];

  always #5 I_CLK = ~I_CLK;

  pbl_top #(.CNT_W(4), .PKT_BITS(20), .GAP_BITS(4), .LOCK_MATCHES(4), .LOSS_MISSES(2))
    dut (.I_CLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_TX_READY, .O_TX_BIT,
    .O_TX_VALID, .O_TX_SOP, .I_RX_BIT, .I_RX_VALID, .O_LOOPBACK, .O_LINE_TX_EN, .O_ERR_WRAP,
    .O_IRQ);

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask : wr
  task automatic rc(input string n, input logic [7:0] a, input logic [15:0] e);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1 v = O_RDATA;
    chk(n, e, v);
  endtask : rc
  // sent bits feed our own history, so an inverted bit costs one mismatch only
  task automatic rx(input int n, input logic e);
    repeat (n) begin
      @(posedge I_CLK);
      I_RX_BIT <= h[14] ^ h[13] ^ e;
      I_RX_VALID <= 1'b1;
      h = {h[13:0], h[14] ^ h[13] ^ e};
    end
    @(posedge I_CLK);
    I_RX_VALID <= 1'b0;
  endtask : rx
  task automatic errs(input int n);
    repeat (n) begin
      rx(1, 1'b1);
      rx(4, 1'b0);
    end
  endtask : errs
  task automatic txw(input int n, input logic st);
    nv = 0;
    ns = 0;
    n1 = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge I_CLK);
      I_TX_READY <= !(st && i inside {[5:9]});
      #1;
      if (O_TX_VALID === 1'b1) begin
        if (nv < 20) b[nv] = O_TX_BIT;
        nv++;
        n1 += int'(O_TX_BIT === 1'b1);
      end
      ns += int'(O_TX_SOP === 1'b1);
    end
  endtask : txw
  task automatic tally_and_finish();
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  always @(posedge I_CLK) begin
    if (O_ERR_WRAP === 1'b1) wraps++;
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    rc("ctrl", CT, 16'h0100);
    rc("cnt", 8'h20, 16'h0000);
    rc("stat", 8'h21, 16'h0000);
    rc("mask", 8'h22, 16'h0000);
    wr(8'h30, 16'hFFFF);
    rc("unmapped", 8'h30, 16'h0000);
    wr(CT, 16'h8003);
    rc("ctrl_ro", CT, 16'h0103);
    el = 4'h0;
    foreach (cd[k]) begin
      wr(CT, {9'h000, 1'b1, cd[k], 2'b00});
      if (cd[k] != 4'h8) el = cd[k];
      #1 chk("lb", {12'h000, el}, {12'h000, O_LOOPBACK});
      chk("line_en", 16'h0001, {15'h0000, O_LINE_TX_EN});
      rc("lb_rd", CT, {9'h002, el inside {4'h1, 4'h2}, el, 2'b00});
    end
    wr(CT, 16'h0004);
    #1 chk("line_off", 16'h0000, {15'h0000, O_LINE_TX_EN});
    wr(CT, 16'h3000);
    txw(45, 1'b0);
    chk("bits", 16'h0028, nv[15:0]);
    chk("sops", 16'h0002, ns[15:0]);
    for (int i = 15; i < 20; i++) chk("prbs", b[i-15] ^ b[i-14], b[i]);
    rc("gen_on", CT, 16'h3300);
    wr(CT, 16'h2000);
    repeat (3) @(posedge I_CLK);
    txw(30, 1'b0);
    chk("gen_off", 16'h0000, nv[15:0]);
    rc("gen_st", CT, 16'h2100);
    wr(8'h21, 16'h000F);
    wr(8'h22, 16'h0008);
    wr(CT, 16'h1000);
    txw(45, 1'b1);
    chk("c_bits", 16'h0014, nv[15:0]);
    chk("c_ones", 16'h0014, n1[15:0]);
    chk("c_sop", 16'h0001, ns[15:0]);
    rx(40, 1'b0);
    rc("c_ctrl", CT, 16'h1100);
    rc("c_cnt", 8'h20, 16'h0000);
    chk("irq_on", 16'h0001, {15'h0000, O_IRQ});
    rc("irq_st", 8'h21, 16'h0008);
    wr(8'h22, 16'h0000);
    #1 chk("irq_mask", 16'h0000, {15'h0000, O_IRQ});
    wr(8'h22, 16'h0008);
    wr(8'h21, 16'h0008);
    #1 chk("irq_clr", 16'h0000, {15'h0000, O_IRQ});
    rc("irq_st0", 8'h21, 16'h0000);
    wr(CT, 16'h2000);
    rx(40, 1'b0);
    rc("lock", CT, 16'h2900);
    wr(8'h21, 16'h000F);
    errs(17);
    rc("cnt_sat", 8'h20, 16'h000F);
    rc("cnt_cor", 8'h20, 16'h0000);
    wr(CT, 16'h6000);
    wraps = 0;
    errs(17);
    chk("wraps", 16'h0001, wraps[15:0]);
    rc("st_wrap", 8'h21, 16'h0004);
    rx(2, 1'b1);
    rc("loss", CT, 16'h6500);
    rc("loss_clr", CT, 16'h6100);
    rc("st_loss", 8'h21, 16'h0005);
    tally_and_finish();
  end
endmodule : pbl_top_tb
